// ===== inc/clock_mode_cfg.svh
// Constants for the clock mode switch and reset block
`ifndef CLOCK_MODE_CFG_SVH
`define CLOCK_MODE_CFG_SVH

// APB geometry
`define PADDR_W            12
`define PDATA_W            32

// Register byte offsets
`define OFF_SYS_CTRL       12'h000
`define OFF_TRAP_CTRL      12'h004
`define OFF_MODE_STAT      12'h008
`define OFF_IRQ_STAT       12'h00c
`define OFF_IRQ_EN         12'h010
`define OFF_IRQ_CLR        12'h014
`define OFF_RST_CAUSE      12'h018

// system_control_two field positions
`define BIT_XEN            7
`define BIT_SLOW_OSC_ENABLE           6
`define BIT_SEL            5

// Trap control field positions
`define BIT_TRAP_RAM_AREA_SELECT           0
`define BIT_TRAP_RST       1

// Mode status field positions
`define BIT_CORE_SLOW      0
`define BIT_MODE_LO        1
`define BIT_MODE_HI        2

// Interrupt status bits
`define IRQ_TRAP           0
`define IRQ_TO_SLOW        1
`define IRQ_TO_FAST        2
`define IRQ_W              3

// Reset cause bits
`define CAUSE_PIN          0
`define CAUSE_TRAP         1
`define CAUSE_WDT          2
`define CAUSE_CLK          3
`define CAUSE_W            4

// Reset values
`define XEN_RST            1'b1
`define SLOW_OSC_ENABLE_RST           1'b0
`define SEL_RST            1'b0
`define TRAP_RAM_AREA_SELECT_RST           1'b0
`define TRAP_RST_RST       1'b1
`define IRQ_RST            3'h0
`define CAUSE_RST          4'h0

// Timing: malfunction reset length in fast clock periods
`define SYS_HZ             50000000
`define FC_HZ              50000000
`define MAL_RST_PERIODS    24
`define MAL_RST_CYCLES     ((`MAL_RST_PERIODS * `SYS_HZ) / `FC_HZ)
`define MAL_CNT_W          5

// Fetch address areas
`define SFR_LO             16'h0000
`define SFR_HI             16'h003f
`define RAM_LO             16'h0040
`define RAM_HI             16'h023f
`define DBR_LO             16'h0f80
`define DBR_HI             16'h0fff
`define RESET_VECTOR       16'hfffe

`endif

// ===== inc/clock_mode_pkg.sv
// Types shared by the clock mode switch and reset block
`default_nettype none
package clock_mode_pkg;

   // Operating modes of the oscillator pair
   typedef enum logic [1:0] {
      FAST_SINGLE_CLOCK_MODE = 2'b00,
      FAST_DUAL_CLOCK_MODE   = 2'b01,
      SLOW_BOTH_OSC_MODE     = 2'b10,
      SLOW_OSC_ONLY_MODE     = 2'b11
   } osc_mode_e;

   // Core clock switch states
   typedef enum logic [1:0] {
      SW_FAST = 2'b00,
      SW_SLOW = 2'b01,
      SW_SYNC = 2'b10
   } clk_sw_e;

   // Clock control bits of system_control_two
   typedef struct packed {
      logic fast_osc_enable;
      logic slow_osc_enable;
      logic main_clock_select;
   } sys_ctrl_s;

   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   // Mode implied by a clock control setting
   function automatic osc_mode_e mode_of(input sys_ctrl_s c);
      if (c.main_clock_select) begin
         mode_of = c.fast_osc_enable ? SLOW_BOTH_OSC_MODE : SLOW_OSC_ONLY_MODE;
      end else begin
         mode_of = c.slow_osc_enable ? FAST_DUAL_CLOCK_MODE : FAST_SINGLE_CLOCK_MODE;
      end
   endfunction

endpackage
`default_nettype wire

// ===== verilog/malfunction_stretch.sv
// Stretches a malfunction reset request to a fixed number of fast clock periods
`timescale 1ns/1ps
`default_nettype none
`include "clock_mode_cfg.svh"

module malfunction_stretch (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic trigger,
   output var  logic active
);

   logic [`MAL_CNT_W-1:0] cnt_r;

   // Load on request and count down; also loaded by the system reset,
   // giving the power-up pulse of the uninitialised malfunction circuit
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r <= `MAL_CNT_W'(`MAL_RST_CYCLES);
      end else if (trigger) begin
         cnt_r <= `MAL_CNT_W'(`MAL_RST_CYCLES);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - `MAL_CNT_W'(1);
      end
   end

   // Active while the count runs
   always_ff @(posedge clk) begin
      if (srst) begin
         active <= 1'b1;
      end else begin
         active <= trigger || (cnt_r > `MAL_CNT_W'(1));
      end
   end

endmodule
`default_nettype wire

// ===== verilog/clock_mode_switch_and_reset.sv
// Clock mode switch between fast and slow oscillators, and reset generation
//
// Function
// - Fast-to-slow: select slow clock, then stop fast.
// - Reset pin leaves slow mode; restart fast single.
// - Core stays slow until clocks synchronise.
// - Four reset sources; malfunction resets last 24 periods.
// - Malfunction logic may pulse reset at power-up.
// - Reset clears interrupt master, enables and latches.
// - Reset clears prescaler, divider; watchdog stays enabled.
// - Release starts execution at the top vector.
// - Fetch from special, buffer or RAM traps.
// - Trap response selectable: reset or interrupt.
// - Illegal oscillator disable raises system clock reset.
// - Offending write leaves oscillators running.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "clock_mode_cfg.svh"

module clock_mode_switch_and_reset (
   input  wire logic        SYS_CLK,
   input  wire logic        SRST,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   // Reset pin, open drain
   input  wire logic        RESET_N_IN,
   output var  logic        RESET_N_OUT,
   output var  logic        RESET_N_OE,
   // Core and neighbours
   input  wire logic        FETCH_VALID,
   input  wire logic [15:0] FETCH_ADDR,
   input  wire logic        WDT_RESET_REQ,
   input  wire logic        CLK_SYNC_TICK,
   output var  logic        FAST_OSC_EN,
   output var  logic        SLOW_OSC_EN,
   output var  logic        CORE_CLK_SLOW,
   output var  logic [1:0]  OSC_MODE,
   output var  logic        CORE_RESET,
   output var  logic        INT_STATE_CLEAR,
   output var  logic        PRESCALER_CLEAR,
   output var  logic        WDT_FORCE_ENABLE,
   output var  logic        VECTOR_FETCH,
   output var  logic [15:0] VECTOR_ADDR,
   output var  logic        TRAP_INT,
   output var  logic        IRQ
);

   clock_mode_pkg::apb_req_s  req;
   clock_mode_pkg::sys_ctrl_s ctrl_r;
   clock_mode_pkg::sys_ctrl_s ctrl_nxt;
   clock_mode_pkg::clk_sw_e   sw_r;
   clock_mode_pkg::clk_sw_e   sw_nxt;

   logic                 trap_ram_area_select_r;
   logic                 trap_to_reset_r;
   logic [`IRQ_W-1:0]    irq_stat_r;
   logic [`IRQ_W-1:0]    irq_en_r;
   logic [`IRQ_W-1:0]    irq_set;
   logic [`IRQ_W-1:0]    irq_clr;
   logic [`CAUSE_W-1:0]  cause_r;
   logic [`CAUSE_W-1:0]  cause_set;
   logic [`CAUSE_W-1:0]  cause_clr;
   logic                 wr_en;
   logic                 rd_setup;
   logic                 addr_ok;
   logic                 wr_ctrl;
   logic                 clk_fault;
   logic                 trap_hit;
   logic                 trap_reset;
   logic                 mal_trigger;
   logic                 mal_active;
   logic                 pin_low;
   logic                 rst_int;
   logic                 rst_any;

   // Address inside an inclusive window
   function automatic logic in_area(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
      in_area = (a >= lo) && (a <= hi);
   endfunction
   // Offset belongs to the register map
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == `OFF_SYS_CTRL) || (a == `OFF_TRAP_CTRL) ||
               (a == `OFF_MODE_STAT) || (a == `OFF_IRQ_STAT) ||
               (a == `OFF_IRQ_EN) || (a == `OFF_IRQ_CLR) ||
               (a == `OFF_RST_CAUSE);
   endfunction

   // Gather the bus request into one word
   assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};
   // Bus phases; the slave answers with no wait states
   assign PREADY   = 1'b1;
   assign addr_ok  = mapped(req.paddr);
   assign wr_en    = req.psel && req.penable && req.pwrite && addr_ok;
   assign rd_setup = req.psel && !req.penable && !req.pwrite;
   assign PSLVERR  = req.psel && req.penable && !addr_ok;
   assign wr_ctrl  = wr_en && (req.paddr == `OFF_SYS_CTRL);
   // Proposed clock control after a write
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt.fast_osc_enable   = req.pwdata[`BIT_XEN];
         ctrl_nxt.slow_osc_enable   = req.pwdata[`BIT_SLOW_OSC_ENABLE];
         ctrl_nxt.main_clock_select = req.pwdata[`BIT_SEL];
      end
   end
   // A write that would stop the oscillator the core needs
   assign clk_fault = wr_ctrl &&
      ((!ctrl_nxt.fast_osc_enable && !ctrl_nxt.slow_osc_enable) ||
       (!ctrl_nxt.fast_osc_enable && !ctrl_nxt.main_clock_select) ||
       (!ctrl_nxt.slow_osc_enable && ctrl_nxt.main_clock_select));
   // Instruction fetch into a forbidden area
   assign trap_hit = FETCH_VALID &&
      (in_area(FETCH_ADDR, `SFR_LO, `SFR_HI) ||
       in_area(FETCH_ADDR, `DBR_LO, `DBR_HI) ||
       (trap_ram_area_select_r && in_area(FETCH_ADDR, `RAM_LO, `RAM_HI)));
   assign trap_reset = trap_hit && trap_to_reset_r;
   // Malfunction reset sources
   assign mal_trigger = trap_reset || WDT_RESET_REQ || clk_fault;

   malfunction_stretch u_stretch (
      .clk     (SYS_CLK),
      .srst    (SRST),
      .trigger (mal_trigger),
      .active  (mal_active)
   );
   // Pin is pulled low while a malfunction reset runs
   assign RESET_N_OUT = 1'b0;
   assign RESET_N_OE  = mal_active;
   // Internal reset from the pin or a malfunction
   assign pin_low = !RESET_N_IN;
   assign rst_int = pin_low || mal_active;
   assign rst_any = SRST || rst_int;

   // Clock control; an illegal write is dropped so the oscillator enables keep their values
   always_ff @(posedge SYS_CLK) begin
      if (rst_any) begin
         ctrl_r.fast_osc_enable   <= `XEN_RST;
         ctrl_r.slow_osc_enable   <= `SLOW_OSC_ENABLE_RST;
         ctrl_r.main_clock_select <= `SEL_RST;
      end else if (wr_ctrl && !clk_fault) begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Core clock switch: slow at once, back to fast only on a sync tick
   always_comb begin
      sw_nxt = sw_r;
      unique case (sw_r)
         clock_mode_pkg::SW_FAST: begin
            if (ctrl_r.main_clock_select) begin
               sw_nxt = clock_mode_pkg::SW_SLOW;
            end
         end
         clock_mode_pkg::SW_SLOW: begin
            if (!ctrl_r.main_clock_select) begin
               sw_nxt = clock_mode_pkg::SW_SYNC;
            end
         end
         clock_mode_pkg::SW_SYNC: begin
            if (ctrl_r.main_clock_select) begin
               sw_nxt = clock_mode_pkg::SW_SLOW;
            end else if (CLK_SYNC_TICK) begin
               sw_nxt = clock_mode_pkg::SW_FAST;
            end
         end
         default: begin
            sw_nxt = clock_mode_pkg::SW_FAST;
         end
      endcase
   end
   // Switch state register
   always_ff @(posedge SYS_CLK) begin
      if (rst_any) begin
         sw_r <= clock_mode_pkg::SW_FAST;
      end else begin
         sw_r <= sw_nxt;
      end
   end

   // Clock outputs
   always_ff @(posedge SYS_CLK) begin
      if (rst_any) begin
         FAST_OSC_EN   <= `XEN_RST;
         SLOW_OSC_EN   <= `SLOW_OSC_ENABLE_RST;
         CORE_CLK_SLOW <= 1'b0;
         OSC_MODE      <= clock_mode_pkg::FAST_SINGLE_CLOCK_MODE;
      end else begin
         FAST_OSC_EN   <= ctrl_r.fast_osc_enable;
         SLOW_OSC_EN   <= ctrl_r.slow_osc_enable;
         CORE_CLK_SLOW <= (sw_nxt != clock_mode_pkg::SW_FAST);
         OSC_MODE      <= clock_mode_pkg::mode_of(ctrl_r);
      end
   end

   // Trap configuration
   always_ff @(posedge SYS_CLK) begin
      if (rst_any) begin
         trap_ram_area_select_r          <= `TRAP_RAM_AREA_SELECT_RST;
         trap_to_reset_r <= `TRAP_RST_RST;
      end else if (wr_en && (req.paddr == `OFF_TRAP_CTRL)) begin
         trap_ram_area_select_r          <= req.pwdata[`BIT_TRAP_RAM_AREA_SELECT];
         trap_to_reset_r <= req.pwdata[`BIT_TRAP_RST];
      end
   end
   // Trap interrupt pulse when the trap is set to interrupt
   always_ff @(posedge SYS_CLK) begin
      if (rst_any) begin
         TRAP_INT <= 1'b0;
      end else begin
         TRAP_INT <= trap_hit && !trap_to_reset_r;
      end
   end

   // Interrupt events and software clears
   assign irq_set[`IRQ_TRAP]    = trap_hit && !trap_to_reset_r;
   assign irq_set[`IRQ_TO_SLOW] = (sw_r == clock_mode_pkg::SW_FAST) &&
                                  (sw_nxt == clock_mode_pkg::SW_SLOW);
   assign irq_set[`IRQ_TO_FAST] = (sw_r == clock_mode_pkg::SW_SYNC) &&
                                  (sw_nxt == clock_mode_pkg::SW_FAST);
   assign irq_clr = (wr_en && (req.paddr == `OFF_IRQ_CLR)) ?
                    req.pwdata[`IRQ_W-1:0] : '0;
   // Sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge SYS_CLK) begin
      if (rst_any) begin
         irq_stat_r <= `IRQ_RST;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      end
   end
   // Interrupt enables
   always_ff @(posedge SYS_CLK) begin
      if (rst_any) begin
         irq_en_r <= `IRQ_RST;
      end else if (wr_en && (req.paddr == `OFF_IRQ_EN)) begin
         irq_en_r <= req.pwdata[`IRQ_W-1:0];
      end
   end
   // Level interrupt output
   always_ff @(posedge SYS_CLK) begin
      if (rst_any) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat_r & irq_en_r);
      end
   end

   // Reset cause events; kept across internal resets for software
   assign cause_set[`CAUSE_PIN]  = pin_low && !mal_active;
   assign cause_set[`CAUSE_TRAP] = trap_reset;
   assign cause_set[`CAUSE_WDT]  = WDT_RESET_REQ;
   assign cause_set[`CAUSE_CLK]  = clk_fault;
   assign cause_clr = (wr_en && (req.paddr == `OFF_RST_CAUSE)) ?
                      req.pwdata[`CAUSE_W-1:0] : '0;
   // Cause register, write one to clear, set wins
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         cause_r <= `CAUSE_RST;
      end else begin
         cause_r <= (cause_r & ~cause_clr) | cause_set;
      end
   end

   // Reset effects seen by the core and neighbours
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         CORE_RESET       <= 1'b1;
         INT_STATE_CLEAR  <= 1'b1;
         PRESCALER_CLEAR  <= 1'b1;
         WDT_FORCE_ENABLE <= 1'b1;
      end else begin
         CORE_RESET       <= rst_int;
         INT_STATE_CLEAR  <= rst_int;
         PRESCALER_CLEAR  <= rst_int;
         WDT_FORCE_ENABLE <= rst_int;
      end
   end
   // Vector fetch pulse at reset release
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         VECTOR_FETCH <= 1'b0;
         VECTOR_ADDR  <= `RESET_VECTOR;
      end else begin
         VECTOR_FETCH <= CORE_RESET && !rst_int;
         VECTOR_ADDR  <= `RESET_VECTOR;
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         PRDATA <= '0;
      end else if (rd_setup) begin
         PRDATA <= '0;
         unique case (req.paddr)
            `OFF_SYS_CTRL: begin
               PRDATA[`BIT_XEN]  <= ctrl_r.fast_osc_enable;
               PRDATA[`BIT_SLOW_OSC_ENABLE] <= ctrl_r.slow_osc_enable;
               PRDATA[`BIT_SEL]  <= ctrl_r.main_clock_select;
            end
            `OFF_TRAP_CTRL: begin
               PRDATA[`BIT_TRAP_RAM_AREA_SELECT]     <= trap_ram_area_select_r;
               PRDATA[`BIT_TRAP_RST] <= trap_to_reset_r;
            end
            `OFF_MODE_STAT: begin
               PRDATA[`BIT_CORE_SLOW]            <= (sw_r != clock_mode_pkg::SW_FAST);
               PRDATA[`BIT_MODE_HI:`BIT_MODE_LO] <= clock_mode_pkg::mode_of(ctrl_r);
            end
            `OFF_IRQ_STAT: begin
               PRDATA[`IRQ_W-1:0] <= irq_stat_r;
            end
            `OFF_IRQ_EN: begin
               PRDATA[`IRQ_W-1:0] <= irq_en_r;
            end
            `OFF_RST_CAUSE: begin
               PRDATA[`CAUSE_W-1:0] <= cause_r;
            end
            default: begin
               PRDATA <= '0; // Clear register and unmapped offsets read zero
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== tb/clock_mode_props.sv
// Port assertions for the clock mode switch and reset block
`timescale 1ns/1ps
`default_nettype none

module clock_mode_props (
   input wire logic        SYS_CLK,
   input wire logic        SRST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        RESET_N_IN,
   input wire logic        RESET_N_OE,
   input wire logic        FETCH_VALID,
   input wire logic [15:0] FETCH_ADDR,
   input wire logic        WDT_RESET_REQ,
   input wire logic        CLK_SYNC_TICK,
   input wire logic        FAST_OSC_EN,
   input wire logic        SLOW_OSC_EN,
   input wire logic        CORE_CLK_SLOW,
   input wire logic [1:0]  OSC_MODE,
   input wire logic        CORE_RESET,
   input wire logic        INT_STATE_CLEAR,
   input wire logic        PRESCALER_CLEAR,
   input wire logic        WDT_FORCE_ENABLE,
   input wire logic        VECTOR_FETCH,
   input wire logic [15:0] VECTOR_ADDR,
   input wire logic        TRAP_INT
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (SRST);

   logic       quiet;
   logic       fault;
   logic [5:0] oe_cnt;

   // Block idle and out of reset; written control value would kill the clock
   assign quiet = RESET_N_IN && !RESET_N_OE && !CORE_RESET;
   assign fault = (!PWDATA[7] && !PWDATA[6]) || (!PWDATA[7] && !PWDATA[5])
                  || (!PWDATA[6] && PWDATA[5]);

   // Counts consecutive cycles the block holds the pin low
   always_ff @(posedge SYS_CLK) begin
      if (SRST || !RESET_N_OE) begin
         oe_cnt <= 6'h00;
      end else if (oe_cnt != 6'h3f) begin
         oe_cnt <= oe_cnt + 6'h01;
      end
   end

   property p_vec;
      VECTOR_FETCH |-> !CORE_RESET && $past(CORE_RESET) && VECTOR_ADDR == 16'hfffe;
   endproperty
   a_vec: assert property (p_vec)
      else $error("vector fetch away from reset release");

   property p_wdt;
      WDT_RESET_REQ && !RESET_N_OE |=> RESET_N_OE ##23 (RESET_N_OE && oe_cnt == 6'h17)
         ##1 !RESET_N_OE;
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("watchdog reset not 24 cycles");

   property p_oe_max;
      RESET_N_OE |-> oe_cnt <= 6'h18;
   endproperty
   a_oe_max: assert property (p_oe_max)
      else $error("pin held low too long");

   property p_clk_fault;
      PSEL && PENABLE && PWRITE && PADDR == 12'h000 && quiet && fault
         |=> RESET_N_OE && $stable(FAST_OSC_EN) && $stable(SLOW_OSC_EN);
   endproperty
   a_clk_fault: assert property (p_clk_fault)
      else $error("clock fault write mishandled");

   property p_pin;
      !RESET_N_IN |=> CORE_RESET && INT_STATE_CLEAR && PRESCALER_CLEAR && WDT_FORCE_ENABLE;
   endproperty
   a_pin: assert property (p_pin)
      else $error("low pin did not reset");

   property p_fast;
      CORE_RESET && $past(CORE_RESET)
         |-> FAST_OSC_EN && !SLOW_OSC_EN && !CORE_CLK_SLOW && OSC_MODE == 2'b00;
   endproperty
   a_fast: assert property (p_fast)
      else $error("reset left slow setting");

   property p_sync;
      $fell(CORE_CLK_SLOW) |-> $past(CLK_SYNC_TICK) || CORE_RESET;
   endproperty
   a_sync: assert property (p_sync)
      else $error("core left slow clock without sync");

   property p_trap;
      FETCH_VALID && quiet && FETCH_ADDR <= 16'h003f |=> TRAP_INT || RESET_N_OE;
   endproperty
   a_trap: assert property (p_trap)
      else $error("special area fetch not trapped");
endmodule

`default_nettype wire

// ===== tb/reset_source_model.sv
// Outside reset source and pull-up on the reset pin
`timescale 1ns/1ps
`default_nettype none

module reset_source_model (
   input  wire logic clk,
   input  wire logic pull_low_oe,
   output var  logic pin_level
);
   logic hold_r = 1'b0;

   // Open drain wire: high by pull-up unless some party pulls it
   assign pin_level = !(hold_r || pull_low_oe === 1'b1);

   // Holds the pin low for n cycles while clock is stable
   task automatic press(input int n);
      @(posedge clk);
      hold_r <= 1'b1;
      repeat (n) @(posedge clk);
      hold_r <= 1'b0;
   endtask
endmodule

`default_nettype wire

// ===== tb/clock_mode_switch_and_reset_bench.sv
// Self-checking bench for the clock mode switch and reset block
`timescale 1ns/1ps
`default_nettype none
`include "clock_mode_cfg.svh"

module clock_mode_switch_and_reset_bench;
   logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr, err, pin, rst_oe, pin_out;
   logic        fetch_valid, wdt_req, sync_tick, fast_en, core_slow, vfetch, trap_int, irq;
   logic [1:0]  osc_mode;
   logic [11:0] paddr;
   logic [15:0] fetch_addr, vaddr;
   logic [31:0] pwdata, prdata, rd;
   logic [31:0] codes [3] = '{32'h00, 32'h40, 32'ha0};
   int          bad_count, total_checks, n;

   clock_mode_switch_and_reset dut_u (
      .SYS_CLK(sys_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RESET_N_IN(pin), .RESET_N_OUT(pin_out), .RESET_N_OE(rst_oe), .FETCH_VALID(fetch_valid),
      .FETCH_ADDR(fetch_addr), .WDT_RESET_REQ(wdt_req), .CLK_SYNC_TICK(sync_tick),
      .FAST_OSC_EN(fast_en), .SLOW_OSC_EN(), .CORE_CLK_SLOW(core_slow), .OSC_MODE(osc_mode),
      .CORE_RESET(), .INT_STATE_CLEAR(), .PRESCALER_CLEAR(), .WDT_FORCE_ENABLE(),
      .VECTOR_FETCH(vfetch), .VECTOR_ADDR(vaddr), .TRAP_INT(trap_int), .IRQ(irq));

   // The block only pulls the pin low if it drives a low level while enabled
   reset_source_model partner_u (.clk(sys_clk), .pull_low_oe(rst_oe && !pin_out),
                                 .pin_level(pin));

   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic close_out;
      if (bad_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic hang;
      bad_count++;
      $display("[ERR] %0t wait ran out", $time);
      close_out();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask

   // One APB transfer: setup, then access until pready
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 40) hang();
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic wrs(input logic [31:0] d);
      xfer(1'b1, `OFF_SYS_CTRL, d);
      repeat (3) @(posedge sys_clk);
   endtask

   // Counts cycles the pin reads low, whoever pulls it, until the vector fetch
   task automatic rel_len(output int c);
      int k;
      c = 0;
      for (k = 0; k < 200; k++) begin
         @(posedge sys_clk);
         if (pin === 1'b0) c++;
         if (vfetch === 1'b1) break;
      end
      if (k == 200) hang();
      chk({16'h0000, vaddr}, 32'hfffe);
   endtask

   // One fetch, then watch for the trap interrupt pulse
   task automatic fetch(input logic [15:0] a, input logic exp);
      logic seen;
      seen = 1'b0;
      @(posedge sys_clk);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      @(posedge sys_clk);
      fetch_valid <= 1'b0;
      repeat (3) begin
         @(posedge sys_clk);
         seen = seen | (trap_int === 1'b1);
      end
      chk({31'h0, seen}, {31'h0, exp});
   endtask

   // Main sequence
   initial begin
      {srst, psel, penable, pwrite, fetch_valid, wdt_req, sync_tick} = 7'h40;
      {paddr, pwdata, fetch_addr} = {12'h000, 32'h0, 16'h0100};
      {bad_count, total_checks} = 0;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      rel_len(n);
      chk({31'h0, n > 0 && n <= 24}, 32'h1);
      rc(`OFF_SYS_CTRL, 32'h80);
      rc(`OFF_MODE_STAT, 32'h0);
      rc(`OFF_IRQ_EN, 32'h0);
      rc(12'h01c, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Fast dual, then slow, then slow with fast oscillator off
      xfer(1'b1, `OFF_IRQ_EN, 32'h6);
      wrs(32'hc0);
      rc(`OFF_MODE_STAT, 32'h2);
      wrs(32'he0);
      rc(`OFF_MODE_STAT, 32'h5);
      rc(`OFF_IRQ_STAT, 32'h2);
      chk({31'h0, irq}, 32'h1);
      xfer(1'b1, `OFF_IRQ_CLR, 32'h2);
      rc(`OFF_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wrs(32'h60);
      chk({30'h0, fast_en, core_slow}, 32'h1);
      chk({30'h0, osc_mode}, 32'h3);
      // Back to fast after warm-up; core waits for the sync tick
      wrs(32'he0);
      repeat (16) @(posedge sys_clk);
      wrs(32'hc0);
      repeat (8) @(posedge sys_clk);
      chk({31'h0, core_slow}, 32'h1);
      sync_tick <= 1'b1;
      @(posedge sys_clk);
      sync_tick <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk({31'h0, core_slow}, 32'h0);
      rc(`OFF_IRQ_STAT, 32'h4);
      // Pin reset out of slow mode
      wrs(32'he0);
      xfer(1'b1, `OFF_RST_CAUSE, 32'hf);
      partner_u.press(12);
      rel_len(n);
      chk(n, 0);
      rc(`OFF_MODE_STAT, 32'h0);
      rc(`OFF_IRQ_EN, 32'h0);
      rc(`OFF_RST_CAUSE, 32'h1);
      // Illegal oscillator settings 00, 40 and a0
      foreach (codes[i]) begin
         xfer(1'b1, `OFF_RST_CAUSE, 32'hf);
         xfer(1'b1, `OFF_SYS_CTRL, codes[i]);
         rel_len(n);
         chk(n, 24);
         xfer(1'b0, `OFF_RST_CAUSE, 32'h0);
         chk({29'h0, rd[3:1]}, 32'h4);
         rc(`OFF_SYS_CTRL, 32'h80);
      end
      // Watchdog request
      xfer(1'b1, `OFF_RST_CAUSE, 32'hf);
      @(posedge sys_clk);
      wdt_req <= 1'b1;
      @(posedge sys_clk);
      wdt_req <= 1'b0;
      rel_len(n);
      chk(n, 24);
      xfer(1'b0, `OFF_RST_CAUSE, 32'h0);
      chk({29'h0, rd[3:1]}, 32'h2);
      // Address trap as interrupt, then as reset
      xfer(1'b1, `OFF_TRAP_CTRL, 32'h0);
      fetch(16'h0100, 1'b0);
      fetch(16'h0010, 1'b1);
      xfer(1'b1, `OFF_TRAP_CTRL, 32'h1);
      fetch(16'h0100, 1'b1);
      fetch(16'h0400, 1'b0);
      rc(`OFF_IRQ_STAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, `OFF_TRAP_CTRL, 32'h3);
      xfer(1'b1, `OFF_RST_CAUSE, 32'hf);
      fetch(16'h0f80, 1'b0);
      rel_len(n);
      xfer(1'b0, `OFF_RST_CAUSE, 32'h0);
      chk({29'h0, rd[3:1]}, 32'h1);
      close_out();
   end

   // Overall run limit
   initial begin
      repeat (20000) @(posedge sys_clk);
      hang();
   end
endmodule

bind clock_mode_switch_and_reset clock_mode_props props_u (
   .SYS_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .RESET_N_IN, .RESET_N_OE,
   .FETCH_VALID, .FETCH_ADDR, .WDT_RESET_REQ, .CLK_SYNC_TICK, .FAST_OSC_EN, .SLOW_OSC_EN,
   .CORE_CLK_SLOW, .OSC_MODE, .CORE_RESET, .INT_STATE_CLEAR, .PRESCALER_CLEAR,
   .WDT_FORCE_ENABLE, .VECTOR_FETCH, .VECTOR_ADDR, .TRAP_INT);

`default_nettype wire
